// >>> src/rx_dma_channel_state_completion.sv
// receive dma channel: state words, byte accounting, length writeback and completion pointer
// assumes: bytes arrive one at a time with a valid strobe and are taken at most every other cycle; memory writes are never stalled
// Summary of operation
// RQ1: bits 31 to 2 of the current-descriptor word hold the descriptor of the buffer now filling.
// RQ2: the buffer-address word holds the full 32-bit byte address for the next received byte.
// RQ3: the packet byte total sits in bits 31 to 16 and is written into word 3 of the first descriptor at end of packet.
// RQ4: bits 15 to 0 of the lengths word hold the free bytes left in the current buffer.
// RQ5: the completion pointer holds bits 31 to 2 of the last end-of-packet descriptor processed.
// RQ6: a completion access with mode bit 0 clear compares bits 31 to 2 and drops the queue interrupt on a match.
// RQ7: a completion access with mode bit 0 set stores bits 31 to 2 and raises the queue interrupt.
// RQ8: the mode bit always reads back as zero.
// RQ9: pointers, address, lengths and counts reset to zero and the reserved low pointer bits read zero.
// RQ10: a 30-bit pointer to the first descriptor of the packet in progress is kept for the writeback.
// RQ11: each stored byte advances the address, lowers the free count, raises the counts (the first-buffer count only while the current descriptor
// equals the stored first-descriptor pointer, which a packet's first byte loads only after its own compare); at zero free bytes the next descriptor is taken.
`default_nettype none
module rx_dma_channel_state_completion (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_last,
    output logic rx_byte_ready,
    output logic mem_wr,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic [3:0] mem_be,
    output logic link_rd,
    output logic [31:0] link_addr,
    input wire logic link_valid,
    input wire logic [31:0] link_next_desc,
    input wire logic [31:0] link_buf_addr,
    input wire logic [15:0] link_buf_len,
    output logic irq
);
    // ****************************************
    // state words
    // ****************************************
    logic [29:0] active_descriptor_pointer_q;
    logic [31:0] active_buffer_address_q;
    logic [15:0] rx_packet_byte_total_q;
    logic [15:0] active_buffer_free_bytes_q;
    logic [15:0] first_buffer_byte_count_q;
    logic [15:0] active_buffer_byte_count_q;
    logic [29:0] packet_first_descriptor_pointer_q;
    logic in_packet_q;
    logic [29:0] completed_descriptor_pointer_q;
    logic queue_irq_q;
    logic [2:0] irq_status_q;
    logic [2:0] irq_mask_q;
    logic enable_q;
    rx_dma_pkg::dma_state_t state_q;

    logic wr_cur, wr_buf, wr_len, wr_cnt, wr_comp, wr_first, wr_stat, wr_mask, wr_ctl;
    logic take_byte;
    logic buffer_filled;
    logic [2:0] irq_event;

    assign wr_cur = reg_wr && (reg_addr == rx_dma_pkg::off_current_descriptor);
    assign wr_buf = reg_wr && (reg_addr == rx_dma_pkg::off_current_buffer_address);
    assign wr_len = reg_wr && (reg_addr == rx_dma_pkg::off_lengths);
    assign wr_cnt = reg_wr && (reg_addr == rx_dma_pkg::off_byte_counts);
    assign wr_comp = reg_wr && (reg_addr == rx_dma_pkg::off_completion_pointer);
    assign wr_first = reg_wr && (reg_addr == rx_dma_pkg::off_first_descriptor);
    assign wr_stat = reg_wr && (reg_addr == rx_dma_pkg::off_irq_status);
    assign wr_mask = reg_wr && (reg_addr == rx_dma_pkg::off_irq_mask);
    assign wr_ctl = reg_wr && (reg_addr == rx_dma_pkg::off_control);

    // bytes are only accepted while a buffer with room is active and no descriptor work is due
    assign take_byte = rx_byte_valid && rx_byte_ready;
    assign buffer_filled = take_byte && (active_buffer_free_bytes_q == 16'h0001);

    // ****************************************
    // descriptor sequencing
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= rx_dma_pkg::st_idle;
        end else begin
            case (state_q)
                rx_dma_pkg::st_idle: begin
                    if (take_byte && rx_byte_last) begin
                        state_q <= rx_dma_pkg::st_write_length;
                    end else if (buffer_filled) begin
                        state_q <= rx_dma_pkg::st_fetch_link; // [RQ11]
                    end
                end
                rx_dma_pkg::st_fetch_link: begin
                    if (link_valid) begin
                        state_q <= rx_dma_pkg::st_idle;
                    end
                end
                rx_dma_pkg::st_write_length: begin
                    state_q <= rx_dma_pkg::st_fetch_link;
                end
                default: state_q <= rx_dma_pkg::st_idle;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_byte_ready <= 1'b0;
        end else begin
            rx_byte_ready <= enable_q && (state_q == rx_dma_pkg::st_idle) && !take_byte
                && (active_buffer_free_bytes_q != 16'h0000);
        end
    end

    // ****************************************
    // current descriptor and buffer address
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            active_descriptor_pointer_q <= rx_dma_pkg::reset_ptr; // [RQ9]
        end else if (state_q == rx_dma_pkg::st_fetch_link && link_valid) begin
            active_descriptor_pointer_q <= link_next_desc[31:2]; // [RQ1] [RQ11]
        end else if (wr_cur) begin
            active_descriptor_pointer_q <= reg_wdata[31:2]; // [RQ1]
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            active_buffer_address_q <= rx_dma_pkg::reset_word; // [RQ9]
        end else if (state_q == rx_dma_pkg::st_fetch_link && link_valid) begin
            active_buffer_address_q <= link_buf_addr;
        end else if (take_byte) begin
            active_buffer_address_q <= active_buffer_address_q + 32'h0000_0001; // [RQ2] [RQ11]
        end else if (wr_buf) begin
            active_buffer_address_q <= reg_wdata; // [RQ2]
        end
    end

    // ****************************************
    // byte accounting
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_packet_byte_total_q <= rx_dma_pkg::reset_half; // [RQ9]
            active_buffer_free_bytes_q <= rx_dma_pkg::reset_half;
            first_buffer_byte_count_q <= rx_dma_pkg::reset_half;
            active_buffer_byte_count_q <= rx_dma_pkg::reset_half;
        end else if (state_q == rx_dma_pkg::st_fetch_link && link_valid) begin
            active_buffer_free_bytes_q <= link_buf_len;
            active_buffer_byte_count_q <= rx_dma_pkg::reset_half;
            if (!in_packet_q) begin
                rx_packet_byte_total_q <= rx_dma_pkg::reset_half;
                first_buffer_byte_count_q <= rx_dma_pkg::reset_half;
            end
        end else if (take_byte) begin
            rx_packet_byte_total_q <= rx_packet_byte_total_q + 16'h0001; // [RQ3] [RQ11]
            active_buffer_free_bytes_q <= active_buffer_free_bytes_q - 16'h0001; // [RQ4] [RQ11]
            active_buffer_byte_count_q <= active_buffer_byte_count_q + 16'h0001;
            if (active_descriptor_pointer_q == packet_first_descriptor_pointer_q) begin
                first_buffer_byte_count_q <= first_buffer_byte_count_q + 16'h0001;
            end
        end else begin
            if (wr_len) begin
                rx_packet_byte_total_q <= reg_wdata[31:16];
                active_buffer_free_bytes_q <= reg_wdata[15:0]; // [RQ4]
            end
            if (wr_cnt) begin
                first_buffer_byte_count_q <= reg_wdata[31:16];
                active_buffer_byte_count_q <= reg_wdata[15:0];
            end
        end
    end

    // ****************************************
    // packet start tracking
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            packet_first_descriptor_pointer_q <= rx_dma_pkg::reset_ptr; // [RQ9]
            in_packet_q <= 1'b0;
        end else if (take_byte && !in_packet_q) begin
            packet_first_descriptor_pointer_q <= active_descriptor_pointer_q; // [RQ10]
            in_packet_q <= !rx_byte_last;
        end else if (take_byte && rx_byte_last) begin
            in_packet_q <= 1'b0;
        end else if (wr_first) begin
            packet_first_descriptor_pointer_q <= reg_wdata[31:2]; // [RQ10]
            in_packet_q <= reg_wdata[0];
        end
    end

    // ****************************************
    // memory and link requests
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mem_wr <= 1'b0;
            mem_addr <= rx_dma_pkg::reset_word;
            mem_wdata <= rx_dma_pkg::reset_word;
            mem_be <= 4'h0;
        end else if (take_byte) begin
            mem_wr <= 1'b1;
            mem_addr <= {active_buffer_address_q[31:2], 2'b00};
            mem_wdata <= {4{rx_byte}};
            mem_be <= 4'h1 << active_buffer_address_q[1:0];
        end else if (state_q == rx_dma_pkg::st_write_length) begin
            // length lands in bits 15:0 of word 3 of the first descriptor
            mem_wr <= 1'b1;
            mem_addr <= {packet_first_descriptor_pointer_q, 2'b00} + rx_dma_pkg::desc_word3_offset;
            mem_wdata <= {rx_dma_pkg::reset_half, rx_packet_byte_total_q}; // [RQ3]
            mem_be <= 4'h3;
        end else begin
            mem_wr <= 1'b0;
            mem_be <= 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            link_rd <= 1'b0;
            link_addr <= rx_dma_pkg::reset_word;
        end else begin
            link_rd <= (state_q == rx_dma_pkg::st_fetch_link) && !link_valid;
            link_addr <= {active_descriptor_pointer_q, 2'b00} + rx_dma_pkg::desc_link_offset;
        end
    end

    // ****************************************
    // completion pointer and queue interrupt
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            completed_descriptor_pointer_q <= rx_dma_pkg::reset_ptr; // [RQ9]
            queue_irq_q <= 1'b0;
        end else if (state_q == rx_dma_pkg::st_write_length) begin
            // hardware completion wins over a same-cycle software access
            completed_descriptor_pointer_q <= active_descriptor_pointer_q; // [RQ5]
            queue_irq_q <= 1'b1;
        end else if (wr_comp && reg_wdata[rx_dma_pkg::ack_mode_bit]) begin
            completed_descriptor_pointer_q <= reg_wdata[31:2]; // [RQ7]
            queue_irq_q <= 1'b1;
        end else if (wr_comp && (reg_wdata[31:2] == completed_descriptor_pointer_q)) begin
            queue_irq_q <= 1'b0; // [RQ6]
        end
    end

    // ****************************************
    // interrupt status, mask and control
    // ****************************************
    // the queue bit marks the rising of the queue interrupt, so a clear is not undone next cycle
    assign irq_event = {!queue_irq_q && ((state_q == rx_dma_pkg::st_write_length)
        || (wr_comp && reg_wdata[rx_dma_pkg::ack_mode_bit])), buffer_filled,
        take_byte && rx_byte_last};

    // set beats clear when both land in one cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_status_q <= rx_dma_pkg::reset_irq;
        end else begin
            irq_status_q <= (irq_status_q & ~(wr_stat ? reg_wdata[2:0] : 3'h0)) | irq_event;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_mask_q <= rx_dma_pkg::reset_irq;
            enable_q <= 1'b0;
        end else begin
            if (wr_mask) begin
                irq_mask_q <= reg_wdata[2:0];
            end
            if (wr_ctl) begin
                enable_q <= reg_wdata[0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_q & irq_mask_q);
        end
    end

    // ****************************************
    // register read port
    // ****************************************
    rx_dma_regfile u_regfile (
        .clk(clk),
        .rstn(rstn),
        .rd_en(reg_rd),
        .addr(reg_addr),
        .word_current_descriptor({active_descriptor_pointer_q, 2'b00}), // [RQ1] [RQ9]
        .word_current_buffer_address(active_buffer_address_q),
        .word_lengths({rx_packet_byte_total_q, active_buffer_free_bytes_q}),
        .word_byte_counts({first_buffer_byte_count_q, active_buffer_byte_count_q}),
        .word_completion_pointer({completed_descriptor_pointer_q, 2'b00}), // [RQ5] [RQ8]
        .word_first_descriptor({packet_first_descriptor_pointer_q, 1'b0, in_packet_q}),
        .word_irq_status({29'h0000_0000, irq_status_q}),
        .word_irq_mask({29'h0000_0000, irq_mask_q}),
        .word_control({31'h0000_0000, enable_q}),
        .rdata(reg_rdata)
    );
endmodule // rx_dma_channel_state_completion
`default_nettype wire

// >>> src/rx_dma_pkg.sv
// package: register offsets, field positions, reset values and states of the rx dma channel block
// assumes: one clock at 200 MHz, plain register port with one-cycle read latency
`default_nettype none
package rx_dma_pkg;
    localparam logic [3:0] off_current_descriptor = 4'h0;
    localparam logic [3:0] off_current_buffer_address = 4'h1;
    localparam logic [3:0] off_lengths = 4'h2;
    localparam logic [3:0] off_byte_counts = 4'h3;
    localparam logic [3:0] off_completion_pointer = 4'h4;
    localparam logic [3:0] off_first_descriptor = 4'h5;
    localparam logic [3:0] off_irq_status = 4'h6;
    localparam logic [3:0] off_irq_mask = 4'h7;
    localparam logic [3:0] off_control = 4'h8;
    localparam int ptr_lsb = 2;
    localparam int high_half_lsb = 16;
    localparam int ack_mode_bit = 0;
    localparam logic [31:0] reset_word = 32'h0000_0000;
    localparam logic [29:0] reset_ptr = 30'h0000_0000;
    localparam logic [15:0] reset_half = 16'h0000;
    // byte offset of word 3 inside a descriptor, where the length is written back
    localparam logic [31:0] desc_word3_offset = 32'h0000_000c;
    // byte offset of the next-descriptor link inside a descriptor
    localparam logic [31:0] desc_link_offset = 32'h0000_0000;
    localparam int irq_bits = 3;
    localparam int irq_eop = 0;
    localparam int irq_buffer_full = 1;
    localparam int irq_queue = 2;
    localparam logic [2:0] reset_irq = 3'h0;
    typedef enum logic [1:0] {st_idle, st_fetch_link, st_write_length} dma_state_t;
endpackage
`default_nettype wire

// >>> src/rx_dma_regfile.sv
// register read mux for the rx dma channel state words
// assumes: address presented with read strobe, data returned one cycle later from a flop
`default_nettype none
module rx_dma_regfile (
    input wire logic clk,
    input wire logic rstn,
    input wire logic rd_en,
    input wire logic [3:0] addr,
    input wire logic [31:0] word_current_descriptor,
    input wire logic [31:0] word_current_buffer_address,
    input wire logic [31:0] word_lengths,
    input wire logic [31:0] word_byte_counts,
    input wire logic [31:0] word_completion_pointer,
    input wire logic [31:0] word_first_descriptor,
    input wire logic [31:0] word_irq_status,
    input wire logic [31:0] word_irq_mask,
    input wire logic [31:0] word_control,
    output logic [31:0] rdata
);
    logic [31:0] rdata_d;

    always_comb begin
        case (addr)
            rx_dma_pkg::off_current_descriptor: rdata_d = word_current_descriptor;
            rx_dma_pkg::off_current_buffer_address: rdata_d = word_current_buffer_address;
            rx_dma_pkg::off_lengths: rdata_d = word_lengths;
            rx_dma_pkg::off_byte_counts: rdata_d = word_byte_counts;
            rx_dma_pkg::off_completion_pointer: rdata_d = word_completion_pointer;
            rx_dma_pkg::off_first_descriptor: rdata_d = word_first_descriptor;
            rx_dma_pkg::off_irq_status: rdata_d = word_irq_status;
            rx_dma_pkg::off_irq_mask: rdata_d = word_irq_mask;
            rx_dma_pkg::off_control: rdata_d = word_control;
            // unmapped offsets read as zero
            default: rdata_d = rx_dma_pkg::reset_word;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata <= rx_dma_pkg::reset_word;
        end else if (rd_en) begin
            rdata <= rdata_d;
        end else begin
            rdata <= rx_dma_pkg::reset_word;
        end
    end
endmodule // rx_dma_regfile
`default_nettype wire

// >>> testbench/rx_dma_assertions.sv
// checker: port-level properties of the rx dma channel block
// assumes: bound to the top module, one clock, rstn synchronous active low
`default_nettype none
module rx_dma_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_last,
    input wire logic rx_byte_ready,
    input wire logic mem_wr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] mem_be,
    input wire logic link_rd,
    input wire logic [31:0] link_addr,
    input wire logic link_valid,
    input wire logic irq
);
    // ****************
    // properties
    // ****************
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic take;
    assign take = rx_byte_valid && rx_byte_ready;
    read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    mode_zero_a: assert property ($past(reg_rd) &&
        $past(reg_addr) == rx_dma_pkg::off_completion_pointer |-> reg_rdata[1:0] == 2'b00)
        else $error("completion mode bit read back set");
    desc_low_a: assert property ($past(reg_rd) &&
        $past(reg_addr) == rx_dma_pkg::off_current_descriptor |-> reg_rdata[1:0] == 2'b00)
        else $error("descriptor low bits read back set");
    byte_write_a: assert property (take |=>
        mem_wr && $onehot(mem_be) && mem_wdata[7:0] == $past(rx_byte))
        else $error("taken byte not written next cycle");
    ready_gap_a: assert property (take |=> !rx_byte_ready)
        else $error("ready not dropped after a take");
    len_write_a: assert property (take && rx_byte_last |->
        ##[2:4] (mem_wr && mem_be == 4'b0011))
        else $error("no length writeback after last byte");
    link_hold_a: assert property (link_rd && !link_valid |=>
        link_rd && $stable(link_addr))
        else $error("link fetch dropped before answer");
    link_refuse_a: assert property (link_rd |-> !rx_byte_ready)
        else $error("byte accepted during descriptor fetch");
    post_reset_a: assert property ($rose(rstn) |->
        !irq && !mem_wr && !link_rd && !rx_byte_ready)
        else $error("outputs not idle after reset");
    cover property (take && rx_byte_last);
    cover property (link_rd && link_valid);
    cover property ($past(reg_rd) && $past(reg_addr) == rx_dma_pkg::off_completion_pointer);
endmodule // rx_dma_checker
bind rx_dma_channel_state_completion rx_dma_checker i_chk (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_byte_last(rx_byte_last),
    .rx_byte_ready(rx_byte_ready), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .link_rd(link_rd), .link_addr(link_addr), .link_valid(link_valid), .irq(irq));
`default_nettype wire

// >>> testbench/rx_link_partner.sv
// partner: descriptor memory answering next-descriptor fetches
// assumes: link_rd is held until link_valid; answers alternate prompt and slow
`default_nettype none
module rx_link_partner #(
    parameter logic [15:0] buf_len = 16'h0004
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic link_rd,
    input wire logic [31:0] link_addr,
    output logic link_valid,
    output logic [31:0] link_next_desc,
    output logic [31:0] link_buf_addr,
    output logic [15:0] link_buf_len
);
    // ****************
    // fetch answer
    // ****************
    logic [2:0] wait_q;
    logic slow_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wait_q <= 3'h0;
            slow_q <= 1'b0;
            link_valid <= 1'b0;
        end else if (link_valid) begin
            link_valid <= 1'b0;
        end else if (link_rd) begin
            if (wait_q == (slow_q ? 3'h4 : 3'h1)) begin
                link_valid <= 1'b1;
                wait_q <= 3'h0;
                slow_q <= ~slow_q;
            end else begin
                wait_q <= wait_q + 3'h1;
            end
        end
    end
    // outside the answer cycle the fields show the inverse, so stale sampling is caught
    assign link_next_desc = link_valid ? link_addr + 32'h0000_0010 : ~(link_addr + 32'h0000_0010);
    assign link_buf_addr = link_valid ? {link_addr[15:0], 16'h0000} : ~{link_addr[15:0], 16'h0000};
    assign link_buf_len = link_valid ? buf_len : ~buf_len;
endmodule // rx_link_partner
`default_nettype wire

// >>> testbench/testbench.sv
// testbench: register, completion pointer, interrupt and packet receive checks
// assumes: design and partner compiled first; 200 MHz clock
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] blen = 16'h0004;
    logic clk, rstn, reg_wr, reg_rd, rx_byte_valid, rx_byte_last, link_valid, rx_byte_ready;
    logic mem_wr, link_rd, irq;
    logic [3:0] reg_addr, mem_be;
    logic [7:0] rx_byte;
    logic [15:0] link_buf_len, fr, n;
    logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, link_addr, link_next_desc;
    logic [31:0] link_buf_addr, seed, rd, cur, ea, p;
    logic [67:0] wq[$];
    int n_mismatch, comparisons, cycles;
    rx_dma_channel_state_completion i_rx_dma_channel_state_completion (.clk(clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
        .rx_byte_last(rx_byte_last), .rx_byte_ready(rx_byte_ready), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be), .link_rd(link_rd),
        .link_addr(link_addr), .link_valid(link_valid), .link_next_desc(link_next_desc),
        .link_buf_addr(link_buf_addr), .link_buf_len(link_buf_len), .irq(irq));
    rx_link_partner #(.buf_len(blen)) i_rx_link_partner (.clk(clk), .rstn(rstn),
        .link_rd(link_rd), .link_addr(link_addr), .link_valid(link_valid),
        .link_next_desc(link_next_desc), .link_buf_addr(link_buf_addr),
        .link_buf_len(link_buf_len));
    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(logic [31:0] g, logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chkr(logic [3:0] a, logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, e);
        @(posedge clk);
    endtask
    task automatic chk_irq(logic e);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge clk);
    endtask
    // only the enabled byte lanes of a memory write are compared
    task automatic chk_mem(logic [31:0] a, logic [31:0] d, logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        repeat (8) if (wq.size() == 0) @(posedge clk);
        if (wq.size() == 0) chk(32'hdead_0000, a);
        else begin
            chk(wq[0][63:32], a);
            chk(wq[0][31:0] & m, d & m);
            chk({28'h0, wq[0][67:64]}, {28'h0, be});
            void'(wq.pop_front());
        end
    endtask
    task automatic send(logic [7:0] b, logic l);
        int k;
        rx_byte <= b;
        rx_byte_last <= l;
        rx_byte_valid <= 1'b1;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (rx_byte_ready !== 1'b1 && k < 50);
        if (k >= 50) chk(32'h0, 32'h1);
        @(posedge clk);
        rx_byte_valid <= 1'b0;
        rx_byte <= ~b;
    endtask
    always @(negedge clk) if (mem_wr === 1'b1) wq.push_back({mem_be, mem_addr, mem_wdata});
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        {rstn, reg_wr, reg_rd, rx_byte_valid, rx_byte_last, reg_addr} = '0;
        {rx_byte, reg_wdata, n_mismatch, comparisons, cycles} = '0;
        seed = 32'h8e4a_1d0b;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a < 16; a++) chkr(a[3:0], 32'h0000_0000);
        $display("test reset_values done");
        seed = lfsr(seed);
        p = seed;
        wr(rx_dma_pkg::off_completion_pointer, {p[31:2], 2'b01});
        chkr(rx_dma_pkg::off_completion_pointer, {p[31:2], 2'b00});
        chkr(rx_dma_pkg::off_irq_status, 32'h0000_0004);
        wr(rx_dma_pkg::off_irq_mask, 32'h0000_0004);
        chk_irq(1'b1);
        wr(rx_dma_pkg::off_irq_status, 32'h0000_0004);
        chk_irq(1'b0);
        wr(rx_dma_pkg::off_completion_pointer, {p[31:2] ^ 30'h1, 2'b00});
        wr(rx_dma_pkg::off_completion_pointer, {p[31:2], 2'b01});
        chkr(rx_dma_pkg::off_irq_status, 32'h0000_0000);
        wr(rx_dma_pkg::off_completion_pointer, {p[31:2], 2'b00});
        wr(rx_dma_pkg::off_completion_pointer, {p[31:2], 2'b01});
        chkr(rx_dma_pkg::off_irq_status, 32'h0000_0004);
        wr(rx_dma_pkg::off_completion_pointer, {p[31:2], 2'b00});
        wr(rx_dma_pkg::off_irq_status, 32'h0000_0004);
        $display("test completion_pointer done");
        for (int t = 0; t < 2; t++) begin
            seed = lfsr(seed);
            cur = {16'h0000, seed[15:4], 4'h0};
            ea = lfsr(seed);
            fr = {14'h0, seed[17:16]} + 16'h0003;
            n = 16'h0000;
            p = cur;
            wr(rx_dma_pkg::off_control, 32'h0000_0000);
            wr(rx_dma_pkg::off_current_descriptor, cur | 32'h0000_0003);
            chkr(rx_dma_pkg::off_current_descriptor, cur);
            wr(rx_dma_pkg::off_current_buffer_address, ea);
            wr(rx_dma_pkg::off_lengths, {16'h0000, fr});
            wr(rx_dma_pkg::off_first_descriptor, cur);
            wr(rx_dma_pkg::off_irq_mask, 32'h0000_0007);
            wr(rx_dma_pkg::off_control, 32'h0000_0001);
            for (int i = 0; i < 5 + t; i++) begin
                seed = lfsr(seed);
                send(seed[7:0], i == 4 + t);
                chk_mem({ea[31:2], 2'b00}, {4{seed[7:0]}}, 4'h1 << ea[1:0]);
                ea = ea + 32'h1;
                fr = fr - 16'h1;
                n = n + 16'h1;
                if (i == 1) chkr(rx_dma_pkg::off_current_buffer_address, ea);
                if (i == 1) chkr(rx_dma_pkg::off_lengths, {n, fr});
                if (fr == 16'h0000 && i != 4 + t) begin
                    cur = cur + 32'h10;
                    ea = {cur[15:0] - 16'h0010, 16'h0000};
                    fr = blen;
                end
            end
            chk_mem(p + 32'h0000_000c, {16'h0000, n}, 4'h3);
            chkr(rx_dma_pkg::off_completion_pointer, cur);
            // the fetch after end of packet must land before the channel is reprogrammed
            repeat (10) @(posedge clk);
        end
        $display("test packet_receive done");
        finish_test();
    end
endmodule // testbench
`default_nettype wire
